/* hw/cpc_pkg.sv */
package cpc_pkg;

  // ********************************************************************
  // Bus widths.
  // ********************************************************************
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // ********************************************************************
  // Register byte addresses.
  // ********************************************************************
  localparam logic [31:0] OFF_PCSR0   = 32'h400E_0418; // Clock status 0.
  localparam logic [31:0] OFF_PLLCFG  = 32'h400E_042C; // Second PLL config.
  localparam logic [31:0] OFF_PCSR1   = 32'h400E_0508; // Clock status 1.
  localparam logic [31:0] OFF_STATUS  = 32'h400E_0468; // Power mgmt status.
  localparam logic [31:0] OFF_IRQMSK  = 32'h400E_046C; // Interrupt mask.
  localparam logic [31:0] OFF_IRQST   = 32'h400E_0470; // Sticky events.
  localparam logic [31:0] OFF_WPMODE  = 32'h400E_04E4; // Write protect mode.
  // Enable and disable ports for the two peripheral clock banks.
  localparam logic [31:0] OFF_PER_EN  [2] = '{32'h400E_0410, 32'h400E_0500};
  localparam logic [31:0] OFF_PER_DIS [2] = '{32'h400E_0414, 32'h400E_0504};
  // Implemented bits of each bank; bits 7..0 of bank 0 carry no status.
  localparam logic [31:0] PER_MASK    [2] = '{32'hFFFF_FF00, 32'hFFFF_FFFF};

  // ********************************************************************
  // Field layout of the second PLL configuration register.
  // ********************************************************************
  localparam int unsigned DIV_LSB  = 0;
  localparam int unsigned DIV_W    = 8;
  localparam int unsigned CNT_LSB  = 8;
  localparam int unsigned CNT_W    = 6;
  localparam int unsigned MUL_LSB  = 16;
  localparam int unsigned MUL_W    = 11;
  localparam logic [31:0] CFG_MASK = 32'h07FF_3FFF;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;

  // ********************************************************************
  // Status, interrupt and protection bit positions.
  // ********************************************************************
  localparam int unsigned LOCK_BIT = 2;  // Lock flag and lock event.
  localparam int unsigned WP_EN_BIT = 0; // Write protect enable.

  // ********************************************************************
  // Timing: core clock and slow clock rates.
  // ********************************************************************
  localparam int unsigned CORE_CLK_HZ  = 25_000_000;
  localparam int unsigned SLOW_CLK_HZ  = 32_768;
  localparam int unsigned SLOW_DIV_DEF = CORE_CLK_HZ / SLOW_CLK_HZ;

  // Lock sequencer states.
  typedef enum logic [1:0] {LK_IDLE, LK_COUNT, LK_DONE} cpc_lock_state_e;

endpackage : cpc_pkg

/* hw/cpc_clock_pll_ctl.sv */
// Function
// - Status bit reads one when clock enabled.
// - Word 0 status only in bits 8..31.
// - Higher identifiers reported in second status word.
// - Divider zero: reference held low, PLL off.
// - Divider one: reference equals input clock.
// - Divider 2..255 divides input by value.
// - Lock flag set after programmed slow cycles.
// - Multiplier zero or divider zero disables PLL.
// - Output factor equals multiplier plus one; zero while PLL off.
// - Config writes ignored while write protect set.
`timescale 1ns/1ps
module cpc_clock_pll_ctl
  import cpc_pkg::*;
#(
  parameter int unsigned SLOW_DIV = SLOW_DIV_DEF  // Core cycles per slow tick.
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_irq,
  output logic      [31:0]       o_per_clk_en0,
  output logic      [31:0]       o_per_clk_en1,
  output logic                   o_pll_ref_tick,
  output logic                   o_pll_enabled,
  output logic      [MUL_W:0]    o_pll_mult_factor,
  output logic                   o_pll_locked
);

  // ********************************************************************
  // Elaboration checks.
  // ********************************************************************
  localparam int unsigned SW = (SLOW_DIV < 2) ? 1 : $clog2(SLOW_DIV);
  generate
    if (SLOW_DIV < 2) begin : g_bad_div
      $error("SLOW_DIV must be at least 2");
    end
  endgenerate

  // Exact address match, used by every decode below.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction : hit

  // ********************************************************************
  // Storage.
  // ********************************************************************
  logic [31:0]      per_en_q [2];  // Peripheral clock enables, two banks.
  logic [31:0]      cfg_q;         // Second PLL configuration.
  logic             wp_q;          // Write protect enable.
  logic [31:0]      irq_st_q;      // Sticky event bits.
  logic [31:0]      irq_msk_q;     // Interrupt mask, same layout.
  logic [DIV_W-1:0] div_cnt_q;     // Front divider phase.
  logic [SW-1:0]    slow_cnt_q;    // Slow clock divider phase.
  logic             slow_tick_q;   // One-cycle slow clock enable.
  logic [CNT_W-1:0] lock_cnt_q;    // Remaining slow cycles to lock.
  cpc_lock_state_e  state_q;       // Lock sequencer state.
  logic             lock_q;        // Lock flag.
  logic [31:0]      rdata_q;       // Registered read data.
  logic             irq_q;         // Registered interrupt.
  logic             ref_tick_q;    // Divided reference pulse.
  logic             pll_en_q;      // Registered PLL enable.
  logic [MUL_W:0]   mult_q;        // Registered multiply factor.

  // ********************************************************************
  // Decode and field extraction.
  // ********************************************************************
  wire              wr_cfg     = i_wr && hit(i_addr, OFF_PLLCFG);
  wire              cfg_accept = wr_cfg && !wp_q;
  wire              wr_wp      = i_wr && hit(i_addr, OFF_WPMODE);
  wire              wr_msk     = i_wr && hit(i_addr, OFF_IRQMSK);
  wire              wr_ist     = i_wr && hit(i_addr, OFF_IRQST);
  wire [DIV_W-1:0]  fdiv       = cfg_q[DIV_LSB +: DIV_W];
  wire [MUL_W-1:0]  fmul       = cfg_q[MUL_LSB +: MUL_W];
  wire [CNT_W-1:0]  new_cnt    = i_wdata[CNT_LSB +: CNT_W];
  // Either field at zero keeps the PLL off.
  wire              pll_en     = (fdiv != '0) && (fmul != '0);
  wire              div_wrap   = (div_cnt_q == fdiv - 8'h01);
  wire              slow_wrap  = (slow_cnt_q == SW'(SLOW_DIV - 1));
  // The lock event fires on the slow tick that exhausts the count.
  wire              lock_set   = (state_q == LK_COUNT) && slow_tick_q &&
                                 (lock_cnt_q <= 6'h01) && pll_en &&
                                 !cfg_accept;
  wire [31:0]       lock_word  = 32'(lock_q) << LOCK_BIT;
  wire [31:0]       wp_word    = 32'(wp_q) << WP_EN_BIT;
  wire [31:0]       lock_ev    = 32'(lock_set) << LOCK_BIT;
  wire [31:0]       ev_mask    = 32'h0000_0001 << LOCK_BIT;
  // Read multiplexer; unmapped addresses read as zero.
  wire [31:0]       rd_val =
      hit(i_addr, OFF_PCSR0)  ? per_en_q[0] :
      hit(i_addr, OFF_PCSR1)  ? per_en_q[1] :
      hit(i_addr, OFF_PLLCFG) ? cfg_q       :
      hit(i_addr, OFF_STATUS) ? lock_word   :
      hit(i_addr, OFF_WPMODE) ? wp_word     :
      hit(i_addr, OFF_IRQMSK) ? irq_msk_q   :
      hit(i_addr, OFF_IRQST)  ? irq_st_q    : 32'h0000_0000;

  // ********************************************************************
  // Peripheral clock enable banks.
  // ********************************************************************
  // Write-one-to-set and write-one-to-clear ports avoid read-modify-write
  // races between drivers that own different peripherals.
  generate
    for (genvar b = 0; b < 2; b++) begin : g_bank
      wire [31:0] set_w = (i_wr && hit(i_addr, OFF_PER_EN[b])) ?
                          i_wdata : 32'h0000_0000;
      wire [31:0] clr_w = (i_wr && hit(i_addr, OFF_PER_DIS[b])) ?
                          i_wdata : 32'h0000_0000;
      wire [31:0] en_d  = ((per_en_q[b] | set_w) & ~clr_w) & PER_MASK[b];
      // Unimplemented positions never latch a one.
      always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
          per_en_q[b] <= 32'h0000_0000;
        end else begin
          per_en_q[b] <= en_d;
        end
      end
    end
  endgenerate

  // ********************************************************************
  // Configuration, protection and interrupt registers.
  // ********************************************************************
  // The protect bit itself is always writable, or it could never clear.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      cfg_q     <= CFG_RST;
      wp_q      <= 1'b0;
      irq_msk_q <= 32'h0000_0000;
      irq_st_q  <= 32'h0000_0000;
    end else begin
      if (cfg_accept) begin
        cfg_q <= i_wdata & CFG_MASK;
      end
      if (wr_wp) begin
        wp_q <= i_wdata[WP_EN_BIT];
      end
      if (wr_msk) begin
        irq_msk_q <= i_wdata & ev_mask;
      end
      // A new event in the clearing cycle survives the clear.
      irq_st_q <= ((irq_st_q & ~(wr_ist ? i_wdata : 32'h0000_0000)) |
                   lock_ev) & ev_mask;
    end
  end

  // ********************************************************************
  // Front-end divider.
  // ********************************************************************
  // A new configuration restarts the phase so the first period is whole.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      div_cnt_q  <= '0;
      ref_tick_q <= 1'b0;
    end else if (cfg_accept || fdiv <= 8'h01) begin
      div_cnt_q  <= '0;
      ref_tick_q <= !cfg_accept && (fdiv == 8'h01);
    end else begin
      div_cnt_q  <= div_wrap ? '0 : div_cnt_q + 8'h01;
      ref_tick_q <= div_wrap;
    end
  end

  // ********************************************************************
  // Slow clock enable.
  // ********************************************************************
  // The slow rate is an enable, not a clock, to keep one domain.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      slow_cnt_q  <= '0;
      slow_tick_q <= 1'b0;
    end else begin
      slow_cnt_q  <= slow_wrap ? '0 : slow_cnt_q + SW'(1);
      slow_tick_q <= slow_wrap;
    end
  end

  // ********************************************************************
  // Lock sequencer.
  // ********************************************************************
  // Lock timing is only as exact as one slow period: the first tick after
  // a write may come early by up to one slow cycle.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state_q    <= LK_IDLE;
      lock_cnt_q <= '0;
      lock_q     <= 1'b0;
    end else if (cfg_accept) begin
      state_q    <= LK_COUNT;
      lock_cnt_q <= new_cnt;
      lock_q     <= 1'b0;
    end else if (!pll_en) begin
      state_q    <= LK_IDLE;
      lock_q     <= 1'b0;
    end else begin
      case (state_q)
        LK_COUNT: begin
          if (lock_set) begin
            state_q <= LK_DONE;
            lock_q  <= 1'b1;
          end else if (slow_tick_q) begin
            lock_cnt_q <= lock_cnt_q - 6'h01;
          end
        end
        LK_DONE: begin
          lock_q <= 1'b1;
        end
        default: begin
          lock_q <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************************
  // Output registers.
  // ********************************************************************
  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rdata_q  <= 32'h0000_0000;
      irq_q    <= 1'b0;
      pll_en_q <= 1'b0;
      mult_q   <= '0;
    end else begin
      rdata_q  <= i_rd ? rd_val : 32'h0000_0000;
      irq_q    <= |(irq_st_q & irq_msk_q);
      pll_en_q <= pll_en;
      mult_q   <= pll_en ? {1'b0, fmul} + 12'h001 : '0;
    end
  end

  assign o_rdata           = rdata_q;
  assign o_irq             = irq_q;
  assign o_per_clk_en0     = per_en_q[0];
  assign o_per_clk_en1     = per_en_q[1];
  assign o_pll_ref_tick    = ref_tick_q;
  assign o_pll_enabled     = pll_en_q;
  assign o_pll_mult_factor = mult_q;
  assign o_pll_locked      = lock_q;

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  // All properties run on the core clock and sleep while reset is low.
  a_status0_bits: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_rd && hit(i_addr, OFF_PCSR0) |=> o_rdata == $past(per_en_q[0]))
    else $error("status word 0 does not show enables");
  a_status0_low: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_rd && hit(i_addr, OFF_PCSR0) |=> o_rdata[7:0] == 8'h00)
    else $error("status word 0 low byte not zero");
  a_en0_low: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_per_clk_en0[7:0] == 8'h00)
    else $error("enable bank 0 low byte not zero");
  a_status1_bits: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    i_rd && hit(i_addr, OFF_PCSR1) |=> o_rdata == $past(per_en_q[1]))
    else $error("status word 1 does not show enables");
  a_div_zero_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    fdiv == 8'h00 |=> !o_pll_ref_tick && !o_pll_enabled)
    else $error("reference active with divider zero");
  a_div_bypass: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    fdiv == 8'h01 && !cfg_accept |=> o_pll_ref_tick)
    else $error("bypassed divider missed a cycle");
  a_div_spacing: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_pll_ref_tick && $past(fdiv) >= 8'h02 |->
      $past(div_cnt_q) == $past(fdiv) - 8'h01)
    else $error("divided reference at wrong phase");
  a_lock_timing: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    $rose(o_pll_locked) |-> $past(slow_tick_q) &&
      $past(lock_cnt_q) <= 6'h01)
    else $error("lock set before count expired");
  a_lock_event: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    lock_set |=> irq_st_q[LOCK_BIT])
    else $error("lock event not recorded");
  a_lock_needs_en: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_pll_locked |-> $past(pll_en))
    else $error("lock flag while PLL disabled");
  a_mult_factor: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    pll_en |=> o_pll_mult_factor == $past(fmul) + 11'd1)
    else $error("multiply factor not field plus one");
  a_wp_ignore: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    wr_cfg && wp_q |=> cfg_q == $past(cfg_q))
    else $error("protected write changed config");
  a_lock_restart: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    cfg_accept |=> !o_pll_locked && lock_cnt_q == $past(new_cnt))
    else $error("accepted write did not restart lock");
  a_lock_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_pll_locked && pll_en && !cfg_accept |=> o_pll_locked)
    else $error("lock flag dropped without cause");
  a_resv_zero: assert property (
    @(posedge i_core_clk) disable iff (!i_nrst)
    (cfg_q & ~CFG_MASK) == 32'h0000_0000)
    else $error("reserved config bits set");

endmodule : cpc_clock_pll_ctl

/* verification/cpc_clock_pll_ctl_test.sv */
`timescale 1ns/1ps
module cpc_clock_pll_ctl_test;
  import cpc_pkg::*;

  // ********************************************************************
  // Clock, reset and design hookup.
  // ********************************************************************
  localparam int SD  = 8;    // Short slow tick so lock waits stay brief.
  localparam int LIM = 4000; // Bound on every wait loop.

  logic              i_core_clk;
  logic              i_nrst;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DATA_W-1:0] o_rdata;
  logic              o_irq;
  logic [31:0]       o_per_clk_en0;
  logic [31:0]       o_per_clk_en1;
  logic              o_pll_ref_tick;
  logic              o_pll_enabled;
  logic [MUL_W:0]    o_pll_mult_factor;
  logic              o_pll_locked;
  int                fails;
  int                checks_done;

  cpc_clock_pll_ctl #(.SLOW_DIV(SD)) dut (
    .i_core_clk       (i_core_clk),
    .i_nrst           (i_nrst),
    .i_addr           (i_addr),
    .i_wdata          (i_wdata),
    .i_wr             (i_wr),
    .i_rd             (i_rd),
    .o_rdata          (o_rdata),
    .o_irq            (o_irq),
    .o_per_clk_en0    (o_per_clk_en0),
    .o_per_clk_en1    (o_per_clk_en1),
    .o_pll_ref_tick   (o_pll_ref_tick),
    .o_pll_enabled    (o_pll_enabled),
    .o_pll_mult_factor(o_pll_mult_factor),
    .o_pll_locked     (o_pll_locked)
  );

  // The 25 MHz core clock.
  initial begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  // ********************************************************************
  // Shared bus, compare and closing tasks.
  // ********************************************************************
  // One write cycle; the strobe drops at the edge that takes it.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask : wr

  // One read cycle; the data stand only in the following cycle.
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  // Compares one value, widened to a word, and counts it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string nm, input logic [31:0] a,
                        input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask : rd_chk

  // Verdict and end of run; also the landing place of a used-up wait.
  task automatic end_sim;
    if (fails == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // Packs divider, lock count and multiplier into a config word.
  function automatic logic [31:0] cfg(input int dv, input int cn,
                                      input int ml);
    return {5'h00, ml[10:0], 2'b00, cn[5:0], dv[7:0]};
  endfunction : cfg

  // Counts edges until the lock flag rises, bounded.
  task automatic wait_lock(output int n);
    n = 0;
    do begin
      @(posedge i_core_clk);
      #1 n++;
    end while (o_pll_locked !== 1'b1 && n < LIM);
    if (o_pll_locked !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask : wait_lock

  // ********************************************************************
  // Scenarios.
  // ********************************************************************
  // Reset values, reserved bits and a stray address.
  task automatic t_reset;
    rd_chk("cfg_rst", OFF_PLLCFG, CFG_RST);
    rd_chk("pcsr0_rst", OFF_PCSR0, 32'h0000_0000);
    chk("irq_rst", 32'h0000_0000, {31'h0, o_irq});
    // Reserved bits all ones; the multiplier stays at a legal 62.
    wr(OFF_PLLCFG, 32'hF83E_FFFF);
    rd_chk("cfg_resv", OFF_PLLCFG, 32'h003E_3FFF);
    wr(OFF_PLLCFG, CFG_RST);
    rd_chk("unmapped", 32'h400E_0600, 32'h0000_0000);
  endtask : t_reset

  // Per-peripheral status words follow enables and disables.
  task automatic t_periph;
    wr(OFF_PER_EN[0], 32'hFFFF_FFFF);
    rd_chk("pcsr0_all", OFF_PCSR0, 32'hFFFF_FF00);
    wr(OFF_PER_DIS[0], 32'h0000_F000);
    wr(OFF_PCSR0, 32'h0000_0000);
    rd_chk("pcsr0_dis", OFF_PCSR0, 32'hFFFF_0F00);
    chk("en0_port", 32'hFFFF_0F00, o_per_clk_en0);
    wr(OFF_PER_EN[1], 32'h8000_0001);
    rd_chk("pcsr1", OFF_PCSR1, 32'h8000_0001);
    chk("en1_port", 32'h8000_0001, o_per_clk_en1);
    rd_chk("en_wo", OFF_PER_EN[0], 32'h0000_0000);
  endtask : t_periph

  // Divider, multiplier and enable over a table of settings.
  // Multipliers stay at zero or 7..62 and the rates are in range.
  task automatic t_pll;
    int dv [5] = '{1, 4, 255, 0, 3};
    int ml [5] = '{7, 9, 62, 9, 0};
    int k;
    logic en;
    for (int i = 0; i < 5; i++) begin
      en = (dv[i] != 0) && (ml[i] != 0);
      wr(OFF_PLLCFG, cfg(dv[i], 1, ml[i]));
      repeat (2) @(posedge i_core_clk);
      #1 chk("pll_en", {31'h0, en}, {31'h0, o_pll_enabled});
      chk("mult", en ? ml[i] + 1 : 0, {20'h0, o_pll_mult_factor});
      k = 0;
      for (int c = 0; c < 10 * (dv[i] == 0 ? 1 : dv[i]); c++) begin
        @(posedge i_core_clk);
        #1 k += int'(o_pll_ref_tick === 1'b1);
      end
      if (ml[i] != 0) begin
        chk("ticks", dv[i] == 0 ? 0 : 10, k);
      end
      repeat (3 * SD) @(posedge i_core_clk);
      #1 chk("lock_en", {31'h0, en}, {31'h0, o_pll_locked});
    end
  endtask : t_pll

  // Lock delay after a write, its event, masking and clearing.
  task automatic t_lock_irq;
    int n;
    wr(OFF_IRQMSK, 32'h0000_0004);
    wr(OFF_IRQST, 32'h0000_0004);
    wr(OFF_PLLCFG, cfg(1, 2, 9));
    wait_lock(n);
    chk("lock_delay", 1, n >= SD + 1 && n <= 2 * SD + 2);
    rd_chk("status", OFF_STATUS, 32'h0000_0004);
    chk("irq_set", 1, {31'h0, o_irq});
    rd_chk("irq_st", OFF_IRQST, 32'h0000_0004);
    wr(OFF_IRQMSK, 32'h0000_0000);
    @(posedge i_core_clk);
    #1 chk("irq_mask", 0, {31'h0, o_irq});
    wr(OFF_IRQMSK, 32'h0000_0004);
    @(posedge i_core_clk);
    #1 chk("irq_unmask", 1, {31'h0, o_irq});
    wr(OFF_IRQST, 32'h0000_0004);
    @(posedge i_core_clk);
    #1 chk("irq_clr", 0, {31'h0, o_irq});
    wr(OFF_PLLCFG, cfg(1, 2, 0));
    repeat (2) @(posedge i_core_clk);
    #1 chk("lock_off", 0, {31'h0, o_pll_locked});
    wr(OFF_PLLCFG, cfg(1, 2, 9));
    wait_lock(n);
  endtask : t_lock_irq

  // A protected write is dropped and leaves the lock alone.
  task automatic t_protect;
    wr(OFF_WPMODE, 32'h0000_0001);
    rd_chk("wp_mode", OFF_WPMODE, 32'h0000_0001);
    wr(OFF_PLLCFG, cfg(5, 3, 20));
    rd_chk("wp_cfg", OFF_PLLCFG, cfg(1, 2, 9));
    chk("wp_lock", 1, {31'h0, o_pll_locked});
    wr(OFF_WPMODE, 32'h0000_0000);
    wr(OFF_PLLCFG, cfg(5, 3, 20));
    rd_chk("wp_off", OFF_PLLCFG, cfg(5, 3, 20));
  endtask : t_protect

  // ********************************************************************
  // Main sequence.
  // ********************************************************************
  initial begin
    fails       = 0;
    checks_done = 0;
    i_nrst  = 1'b0;
    i_addr  = '0;
    i_wdata = '0;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    repeat (10) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_periph();
    t_pll();
    t_lock_irq();
    t_protect();
    end_sim();
  end

endmodule : cpc_clock_pll_ctl_test
